// file: dsc_sequencer.sv
// Configuration, instruction memory and sequencer of the acquisition device.
`timescale 1ns/10ps
module dsc_sequencer #(
   parameter int NUM_INSTR = dsc_pkg::NUM_INSTR_DEF
) (
   input  wire logic                clk,
   input  wire logic                reset,
   input  wire dsc_pkg::dsc_host_s  hostReq,
   output logic [15:0]              hostRdData,
   input  wire logic [15:0]         timerPreset,
   input  wire dsc_pkg::dsc_eng_s   engineAns,
   output logic                     engineReq,
   output dsc_pkg::dsc_op_e         engineOp,
   output logic                     engineLowRes,
   output logic [2:0]               posSel,
   output logic [2:0]               negSel,
   output logic                     sampleHold,
   input  wire logic                syncIn,
   output logic                     syncOut,
   output logic                     syncOe,
   output dsc_pkg::dsc_result_s     result,
   output logic                     limitEvent,
   output logic                     clearAll,
   output logic                     standbyMode,
   output logic [2:0]               instrNum
);

   // The tag field and the pointer are three bits wide.
   if (NUM_INSTR < 1 || NUM_INSTR > 8) begin : g_bad_depth
      $error("NUM_INSTR must lie between 1 and 8");
   end

   logic [15:0]         instrMem [NUM_INSTR];
   logic [15:0]         lim1Mem  [NUM_INSTR];
   logic [15:0]         lim2Mem  [NUM_INSTR];
   dsc_pkg::dsc_cfg_s   cfg_q, cfg_d;
   logic [1:0]          rstCnt_q, rstCnt_d;
   logic                prevStandby_q;
   dsc_pkg::dsc_state_e state_q, state_d;
   logic [2:0]          ptr_q, ptr_d;
   logic [21:0]         cnt_q, cnt_d;
   dsc_pkg::dsc_instr_s cur_q, cur_d;
   dsc_pkg::dsc_op_e    op_q, op_d;
   logic                pauseSkip_q, pauseSkip_d;
   dsc_pkg::dsc_result_s result_q, result_d;
   logic                event_q, event_d;
   logic                syncOut_q, syncOut_d;
   logic [15:0]         rd_q, rd_d;
   logic                sync1_q, sync2_q, sync3_q;

   // Host decode.
   wire                 addrOk   = 32'(hostReq.addr) < NUM_INSTR;
   wire                 cfgWrite = hostReq.wr && !hostReq.sel;
   wire                 ramWrite = hostReq.wr && hostReq.sel && addrOk;
   wire                 wrInstr  = ramWrite
                                   && cfg_q.ramSel == dsc_pkg::SEL_INSTR;
   wire                 wrLim1   = ramWrite
                                   && cfg_q.ramSel == dsc_pkg::SEL_LIM1;
   wire                 wrLim2   = ramWrite
                                   && cfg_q.ramSel == dsc_pkg::SEL_LIM2;
   wire                 hostSetsReset = cfgWrite && hostReq.data[1];
   wire                 standbyExit   = prevStandby_q && !cfg_q.standby;

   // Sequencer view of memory.
   wire dsc_pkg::dsc_instr_s fetched = instrMem[ptr_q];
   wire dsc_pkg::dsc_limit_s limA    = lim1Mem[ptr_q];
   wire dsc_pkg::dsc_limit_s limB    = lim2Mem[ptr_q];
   wire                 pauseHit = state_q == dsc_pkg::S_FETCH
                                   && fetched.pause && !pauseSkip_q;
   wire                 engDone  = engineAns.done && engineReq;
   wire                 calDone  = state_q == dsc_pkg::S_CAL && engDone;
   wire                 lastSlot = 32'(ptr_q) == NUM_INSTR - 1;
   wire [2:0]           ptrNext  = (cur_q.loop || lastSlot) ? 3'h0
                                   : ptr_q + 3'h1;
   wire [5:0]           acqLen   = 6'({cur_q.acqTime, 1'b0})
                                   + (cur_q.lowRes ? dsc_pkg::ACQ_BASE_LO
                                      : dsc_pkg::ACQ_BASE_HI);
   wire [21:0]          tmrLen   = 22'(22'(fetched.delay ? timerPreset
                                   : 16'h0000) * dsc_pkg::TMR_MULT
                                   + dsc_pkg::TMR_ADD);
   wire                 syncRise = sync2_q && !sync3_q;

   function automatic logic signed [9:0] smVal(input logic s,
                                               input logic [7:0] m);
      smVal = s ? -$signed({2'h0, m}) : $signed({2'h0, m});
   endfunction : smVal

   function automatic logic crossed(input logic signed [9:0] v,
                                    input dsc_pkg::dsc_limit_s l);
      crossed = l.above ? v > smVal(l.sign, l.mag)
                : v < smVal(l.sign, l.mag);
   endfunction : crossed

   wire signed [9:0]    inVal = smVal(engineAns.sign, engineAns.mag[11:4]);
   wire [2:0]           tag   = cfg_q.tagSign ? {3{engineAns.sign}}
                                : ptr_q;
   wire [11:0]          body  = cur_q.lowRes
                                ? {engineAns.mag[11:4], dsc_pkg::LOW_FILL}
                                : engineAns.mag;

   // Configuration register next value.
   always_comb begin
      cfg_d    = cfg_q;
      rstCnt_d = 2'h0;
      if (pauseHit) cfg_d.start = 1'b0;
      if (calDone && op_q == dsc_pkg::OP_FULL_CAL) cfg_d.fullCal = 1'b0;
      if (calDone && op_q == dsc_pkg::OP_LONG_AZ) cfg_d.longAz = 1'b0;
      if (cfgWrite) cfg_d = hostReq.data;
      if (standbyExit) cfg_d.softReset = 1'b1;
      if (cfg_q.softReset) begin
         rstCnt_d    = rstCnt_q + 2'h1;
         cfg_d.start = 1'b0;
         if (rstCnt_q == dsc_pkg::RST_LAST && !hostSetsReset) begin
            cfg_d.softReset = 1'b0;
         end else begin
            // A host write of zero must not cut the pulse short.
            cfg_d.softReset = 1'b1;
         end
      end
   end

   // Sequencer next state.
   always_comb begin
      state_d     = state_q;
      ptr_d       = ptr_q;
      cnt_d       = cnt_q;
      cur_d       = cur_q;
      op_d        = op_q;
      pauseSkip_d = pauseSkip_q;
      result_d    = '0;
      event_d     = 1'b0;
      syncOut_d   = 1'b0;
      case (state_q)
         dsc_pkg::S_IDLE: begin
            if (cfg_q.fullCal) begin
               op_d    = dsc_pkg::OP_FULL_CAL;
               state_d = dsc_pkg::S_CAL;
            end else if (cfg_q.longAz) begin
               op_d    = dsc_pkg::OP_LONG_AZ;
               state_d = dsc_pkg::S_CAL;
            end else if (cfg_q.start) begin
               state_d = dsc_pkg::S_FETCH;
            end
         end
         dsc_pkg::S_CAL: begin
            if (engDone) state_d = dsc_pkg::S_IDLE;
         end
         dsc_pkg::S_FETCH: begin
            if (pauseHit) begin
               // The resumed run must not trip on the same pause again.
               pauseSkip_d = 1'b1;
               state_d     = dsc_pkg::S_IDLE;
            end else begin
               pauseSkip_d = 1'b0;
               cur_d       = fetched;
               cnt_d       = tmrLen;
               state_d     = fetched.delay ? dsc_pkg::S_TIMER
                             : dsc_pkg::S_PRE;
            end
         end
         dsc_pkg::S_TIMER: begin
            cnt_d = cnt_q - 22'h000001;
            if (cnt_q <= 22'h000001) state_d = dsc_pkg::S_PRE;
         end
         dsc_pkg::S_PRE: begin
            cnt_d = {16'h0000, acqLen};
            if (cfg_q.azEach) begin
               op_d    = dsc_pkg::OP_SHORT_AZ;
               state_d = dsc_pkg::S_AZ;
            end else begin
               state_d = dsc_pkg::S_ACQ;
            end
         end
         dsc_pkg::S_AZ: begin
            if (engDone) state_d = dsc_pkg::S_ACQ;
         end
         dsc_pkg::S_ACQ: begin
            cnt_d = cnt_q - 22'h000001;
            op_d  = cur_q.watchdog ? dsc_pkg::OP_COMPARE
                    : dsc_pkg::OP_CONV;
            if (cnt_q <= 22'h000001) begin
               state_d = cur_q.extSync ? dsc_pkg::S_SYNC
                         : dsc_pkg::S_CONV;
            end
         end
         dsc_pkg::S_SYNC: begin
            // Only an input pin can deliver the edge; as an output the
            // device paces itself rather than hang.
            if (syncRise || cfg_q.syncDir) begin
               state_d   = dsc_pkg::S_CONV;
               syncOut_d = cfg_q.syncDir;
            end
         end
         dsc_pkg::S_CONV: begin
            if (engDone) begin
               if (cur_q.watchdog) begin
                  event_d = crossed(inVal, limA)
                            || crossed(inVal, limB);
               end else begin
                  result_d.valid = 1'b1;
                  result_d.word  = {tag, engineAns.sign, body};
               end
               ptr_d   = ptrNext;
               state_d = dsc_pkg::S_IDLE;
            end
         end
         dsc_pkg::S_STANDBY: begin
            if (!cfg_q.standby) state_d = dsc_pkg::S_IDLE;
         end
         default: state_d = dsc_pkg::S_IDLE;
      endcase
      if (cfg_q.softReset) begin
         state_d     = dsc_pkg::S_IDLE;
         ptr_d       = 3'h0;
         pauseSkip_d = 1'b0;
      end
      if (cfg_q.standby) state_d = dsc_pkg::S_STANDBY;
   end

   // Host read path; memories answer in standby too.
   always_comb begin
      rd_d = 16'h0000;
      if (!hostReq.sel) begin
         rd_d = cfg_q;
      end else if (addrOk) begin
         case (cfg_q.ramSel)
            dsc_pkg::SEL_INSTR: rd_d = instrMem[hostReq.addr];
            dsc_pkg::SEL_LIM1:  rd_d = lim1Mem[hostReq.addr];
            dsc_pkg::SEL_LIM2:  rd_d = lim2Mem[hostReq.addr];
            default:            rd_d = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (wrInstr) instrMem[hostReq.addr] <= hostReq.data;
      if (wrLim1) lim1Mem[hostReq.addr] <= hostReq.data;
      if (wrLim2) lim2Mem[hostReq.addr] <= hostReq.data;
   end

   always_ff @(posedge clk) begin
      sync1_q <= syncIn;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cfg_q         <= dsc_pkg::CFG_RESET;
         rstCnt_q      <= 2'h0;
         prevStandby_q <= 1'b0;
         rd_q          <= 16'h0000;
      end else begin
         cfg_q         <= cfg_d;
         rstCnt_q      <= rstCnt_d;
         prevStandby_q <= cfg_q.standby;
         rd_q          <= rd_d;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_q     <= dsc_pkg::S_IDLE;
         ptr_q       <= 3'h0;
         cnt_q       <= 22'h000000;
         cur_q       <= '0;
         op_q        <= dsc_pkg::OP_CONV;
         pauseSkip_q <= 1'b0;
         result_q    <= '0;
         event_q     <= 1'b0;
         syncOut_q   <= 1'b0;
      end else begin
         state_q     <= state_d;
         ptr_q       <= ptr_d;
         cnt_q       <= cnt_d;
         cur_q       <= cur_d;
         op_q        <= op_d;
         pauseSkip_q <= pauseSkip_d;
         result_q    <= result_d;
         event_q     <= event_d;
         syncOut_q   <= syncOut_d;
      end
   end

   assign hostRdData   = rd_q;
   assign engineReq    = state_q == dsc_pkg::S_CAL
                         || state_q == dsc_pkg::S_AZ
                         || state_q == dsc_pkg::S_CONV;
   assign engineOp     = op_q;
   assign engineLowRes = cur_q.lowRes;
   assign posSel       = cur_q.posSel;
   assign negSel       = cur_q.negSel;
   assign sampleHold   = state_q == dsc_pkg::S_ACQ
                         || state_q == dsc_pkg::S_SYNC;
   assign syncOut      = syncOut_q;
   assign syncOe       = cfg_q.syncDir;
   assign result       = result_q;
   assign limitEvent   = event_q;
   assign clearAll     = cfg_q.softReset;
   assign standbyMode  = cfg_q.standby;
   assign instrNum     = ptr_q;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   a_reset_selfclear: assert property (
      $rose(cfg_q.softReset) ##1 !hostSetsReset |=> !cfg_q.softReset)
      else $error("soft reset bit did not clear after two cycles");

   a_reset_halts: assert property (
      cfg_q.softReset && !cfg_q.standby
      |=> !cfg_q.start && ptr_q == 3'h0 && state_q == dsc_pkg::S_IDLE)
      else $error("soft reset did not halt the sequencer");

   a_standby_hold: assert property (
      cfg_q.standby |=> state_q == dsc_pkg::S_STANDBY)
      else $error("standby bit did not hold standby state");

   a_pause_stop: assert property (
      pauseHit && !hostReq.wr && !cfg_q.standby
      |=> !cfg_q.start && state_q == dsc_pkg::S_IDLE)
      else $error("pause did not stop the sequencer");

   a_loop_zero: assert property (
      state_q == dsc_pkg::S_CONV && engDone && cur_q.loop
      && !cfg_q.softReset && !cfg_q.standby |=> ptr_q == 3'h0)
      else $error("loop bit did not return to instruction zero");

   a_timer_len: assert property (
      state_q == dsc_pkg::S_FETCH && !pauseHit && fetched.delay
      && !cfg_q.softReset && !cfg_q.standby
      |=> state_q == dsc_pkg::S_TIMER && cnt_q == 22'(22'($past(timerPreset))
          * dsc_pkg::TMR_MULT + dsc_pkg::TMR_ADD))
      else $error("timer delay length wrong");

   a_acq_len: assert property (
      state_q == dsc_pkg::S_PRE && !cur_q.lowRes && cur_q.acqTime == 4'h0
      && !cfg_q.azEach && !cfg_q.softReset && !cfg_q.standby
      |=> (state_q == dsc_pkg::S_ACQ)[*8] ##1 state_q == dsc_pkg::S_ACQ)
      else $error("acquisition time too short");

   a_result_tag: assert property (
      result_q.valid |-> result_q.word[15:13] == ($past(cfg_q.tagSign)
         ? {3{result_q.word[12]}} : $past(ptr_q)))
      else $error("result tag bits wrong");

   a_low_fill: assert property (
      result_q.valid && $past(cur_q.lowRes)
      |-> result_q.word[3:0] == dsc_pkg::LOW_FILL)
      else $error("8-bit result fill pattern wrong");

endmodule : dsc_sequencer

// file: dsc_pkg.sv
// Shared types and constants for the acquisition sequencer control block.
package dsc_pkg;

   localparam int          NUM_INSTR_DEF = 8;
   localparam logic [15:0] CFG_RESET     = 16'h0000;
   localparam logic [1:0]  SEL_INSTR     = 2'h0;
   localparam logic [1:0]  SEL_LIM1      = 2'h1;
   localparam logic [1:0]  SEL_LIM2      = 2'h2;
   // Soft reset counter value seen in the second cycle of the pulse.
   localparam logic [1:0]  RST_LAST      = 2'h1;
   localparam logic [5:0]  ACQ_BASE_HI   = 6'h09;
   localparam logic [5:0]  ACQ_BASE_LO   = 6'h02;
   localparam logic [21:0] TMR_MULT      = 22'h000020;
   localparam logic [21:0] TMR_ADD       = 22'h000002;
   localparam logic [3:0]  LOW_FILL      = 4'hE;

   typedef struct packed {
      logic [3:0] unused;
      logic       diag;
      logic       test;
      logic [1:0] ramSel;
      logic       syncDir;
      logic       azEach;
      logic       tagSign;
      logic       standby;
      logic       fullCal;
      logic       longAz;
      logic       softReset;
      logic       start;
   } dsc_cfg_s;

   typedef struct packed {
      logic [3:0] acqTime;
      logic       watchdog;
      logic       lowRes;
      logic       delay;
      logic       extSync;
      logic [2:0] negSel;
      logic [2:0] posSel;
      logic       pause;
      logic       loop;
   } dsc_instr_s;

   typedef struct packed {
      logic [5:0] unused;
      logic       above;
      logic       sign;
      logic [7:0] mag;
   } dsc_limit_s;

   typedef struct packed {
      logic        sel;
      logic [2:0]  addr;
      logic        wr;
      logic [15:0] data;
   } dsc_host_s;

   typedef struct packed {
      logic        done;
      logic        sign;
      logic [11:0] mag;
   } dsc_eng_s;

   typedef struct packed {
      logic        valid;
      logic [15:0] word;
   } dsc_result_s;

   typedef enum logic [2:0] {
      OP_CONV     = 3'b000,
      OP_COMPARE  = 3'b001,
      OP_SHORT_AZ = 3'b010,
      OP_LONG_AZ  = 3'b011,
      OP_FULL_CAL = 3'b100
   } dsc_op_e;

   typedef enum logic [3:0] {
      S_IDLE    = 4'b0000,
      S_CAL     = 4'b0001,
      S_FETCH   = 4'b0010,
      S_TIMER   = 4'b0011,
      S_PRE     = 4'b0100,
      S_AZ      = 4'b0101,
      S_ACQ     = 4'b0110,
      S_SYNC    = 4'b0111,
      S_CONV    = 4'b1000,
      S_STANDBY = 4'b1001
   } dsc_state_e;

endpackage : dsc_pkg

// file: dsc_engine_model.sv
// Behavioural conversion engine that answers the sequencer's requests.
`timescale 1ns/10ps
module dsc_engine_model (
   input  wire logic         clk,
   input  wire logic         reset,
   input  wire logic         engineReq,
   input  wire logic [3:0]   lag,
   input  wire logic         valSign,
   input  wire logic [11:0]  valMag,
   output dsc_pkg::dsc_eng_s engineAns
);
   logic [3:0] cnt;
   logic       done;
   // Data lines carry the inverse outside the done cycle, so a sequencer
   // that samples late shows a wrong result instead of a lucky match.
   assign engineAns = done ? {1'b1, valSign, valMag}
                           : {1'b0, ~valSign, ~valMag};
   always_ff @(posedge clk) begin
      if (reset || !engineReq) begin
         cnt  <= 4'h0;
         done <= 1'b0;
      end else if (!done && cnt == lag) begin
         done <= 1'b1;
      end else begin
         cnt  <= cnt + 4'h1;
         done <= 1'b0;
      end
   end
endmodule : dsc_engine_model

// file: dsc_sequencer_tb_top.sv
// Self-checking testbench for the acquisition sequencer control block.
`timescale 1ns/10ps
module dsc_sequencer_tb_top;
   logic                 clk = 1'b0;
   logic                 reset = 1'b1;
   dsc_pkg::dsc_host_s   hostReq = '0;
   logic [15:0]          hostRdData;
   logic [15:0]          timerPreset = 16'h0000;
   dsc_pkg::dsc_eng_s    engineAns;
   dsc_pkg::dsc_op_e     engineOp;
   dsc_pkg::dsc_result_s result;
   logic                 engineReq, engineLowRes, sampleHold;
   logic                 syncOut, syncOe, limitEvent, clearAll;
   logic                 standbyMode;
   logic [2:0]           posSel, negSel, instrNum;
   logic                 syncIn = 1'b0;
   logic [3:0]           lag = 4'h3;
   logic                 valSign = 1'b1;
   logic [11:0]          valMag = 12'hABC;
   logic                 reqPrev = 1'b0;
   dsc_pkg::dsc_op_e     ops[$];
   int                   errorCnt = 0;
   int                   nCompared = 0;
   int                   tBase, t, w, k;

   always #20 clk = ~clk;

   dsc_sequencer #(.NUM_INSTR(8)) dsc_sequencer_i (
      .clk(clk), .reset(reset), .hostReq(hostReq),
      .hostRdData(hostRdData), .timerPreset(timerPreset),
      .engineAns(engineAns), .engineReq(engineReq), .engineOp(engineOp),
      .engineLowRes(engineLowRes), .posSel(posSel), .negSel(negSel),
      .sampleHold(sampleHold), .syncIn(syncIn), .syncOut(syncOut),
      .syncOe(syncOe), .result(result), .limitEvent(limitEvent),
      .clearAll(clearAll), .standbyMode(standbyMode), .instrNum(instrNum)
   );

   dsc_engine_model dsc_engine_model_i (
      .clk(clk), .reset(reset), .engineReq(engineReq), .lag(lag),
      .valSign(valSign), .valMag(valMag), .engineAns(engineAns)
   );

   // Records the operation code at the start of every engine request.
   always @(posedge clk) begin
      reqPrev <= engineReq;
      if (engineReq && !reqPrev) begin
         ops.push_back(engineOp);
      end
   end

   task automatic completeRun();
      $display("compared %0d mismatches %0d", nCompared, errorCnt);
      if (errorCnt == 0 && nCompared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : completeRun

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      nCompared++;
      if (seen !== exp) begin
         errorCnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   function automatic logic sigOf(input int s);
      case (s)
         0: return result.valid;
         1: return engineReq;
         2: return sampleHold;
         3: return clearAll;
         default: return syncOut;
      endcase
   endfunction : sigOf

   // Counts edges until the chosen output reaches the level; bounded.
   task automatic waitSig(input int s, input logic lvl, output int n);
      n = 0;
      #1;
      while (sigOf(s) !== lvl) begin
         @(posedge clk);
         #1;
         n++;
         if (n > 400) begin
            errorCnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, ~lvl, lvl);
            completeRun();
         end
      end
   endtask : waitSig

   task automatic wr(input logic s, input logic [2:0] a,
                     input logic [15:0] d);
      @(posedge clk);
      hostReq <= '{sel: s, addr: a, wr: 1'b1, data: d};
      @(posedge clk);
      hostReq.wr <= 1'b0;
   endtask : wr

   task automatic rc(input logic s, input logic [2:0] a,
                     input logic [15:0] e);
      @(posedge clk);
      hostReq <= '{sel: s, addr: a, wr: 1'b0, data: 16'h0000};
      @(posedge clk);
      #1;
      check(hostRdData, e);
   endtask : rc

   task automatic pulse2();
      waitSig(3, 1'b1, w);
      waitSig(3, 1'b0, w);
      check(16'(w), 16'h0002);
   endtask : pulse2

   task automatic softRst();
      wr(1'b0, 3'h0, 16'h0002);
      pulse2();
      rc(1'b0, 3'h0, 16'h0000);
      check(16'(instrNum), 16'h0000);
   endtask : softRst

   // Starts with the given configuration and returns once the engine
   // is asked to convert; t0 is the lead-in, hw the sample time.
   task automatic conv(input logic [15:0] cfg, output int t0,
                       output int hw);
      wr(1'b0, 3'h0, cfg);
      waitSig(2, 1'b1, t0);
      waitSig(2, 1'b0, hw);
      waitSig(1, 1'b1, t);
   endtask : conv

   task automatic sReset();
      rc(1'b0, 3'h0, dsc_pkg::CFG_RESET);
      check(16'({standbyMode, clearAll, result.valid, instrNum}),
            16'h0000);
   endtask : sReset

   task automatic sMem();
      wr(1'b0, 3'h0, 16'h0010);
      for (k = 0; k < 3; k++) begin
         wr(1'b0, 3'h0, 16'h0010 | 16'(k << 8));
         wr(1'b1, 3'h7, 16'h1230 + 16'(k));
      end
      wr(1'b0, 3'h0, 16'h0310);
      wr(1'b1, 3'h7, 16'hDEAD);
      rc(1'b1, 3'h7, 16'h0000);
      check(16'(standbyMode), 16'h0001);
      for (k = 0; k < 3; k++) begin
         wr(1'b0, 3'h0, 16'h0010 | 16'(k << 8));
         rc(1'b1, 3'h7, 16'h1230 + 16'(k));
      end
      wr(1'b0, 3'h0, 16'h0000);
      pulse2();
      check(16'(standbyMode), 16'h0000);
   endtask : sMem

   task automatic sConv();
      wr(1'b1, 3'h0, 16'h2074);
      wr(1'b1, 3'h1, 16'h0002);
      conv(16'h0001, tBase, w);
      check(16'(w), 16'h000D);
      check(16'(engineOp), 16'(dsc_pkg::OP_CONV));
      check(16'({posSel, negSel, engineLowRes}), 16'h0056);
      waitSig(0, 1'b1, t);
      check(result.word, 16'h1ABC);
      check(16'(instrNum), 16'h0001);
      repeat (20) @(posedge clk);
      rc(1'b0, 3'h0, 16'h0000);
      check(16'(ops.size()), 16'h0001);
   endtask : sConv

   task automatic sResume();
      wr(1'b1, 3'h1, 16'h140B);
      conv(16'h0021, t, w);
      check(16'(w), 16'h0004);
      check(16'({posSel, negSel, engineLowRes}), 16'h0021);
      waitSig(0, 1'b1, t);
      check(result.word, 16'hFABE);
      check(16'(instrNum), 16'h0000);
      softRst();
   endtask : sResume

   task automatic sTimer();
      wr(1'b1, 3'h0, 16'h2274);
      for (k = 0; k < 2; k++) begin
         @(posedge clk);
         timerPreset <= 16'(k);
         conv(16'h0001, t, w);
         check(16'(t - tBase), 16'(32 * k + 2));
         waitSig(0, 1'b1, t);
         softRst();
      end
   endtask : sTimer

   task automatic sWatch();
      logic [15:0] l1 [3] = '{16'h0250, 16'h02F0, 16'h02F0};
      logic [12:0] vin [3] = '{13'h0AB0, 13'h0AB0, 13'h1200};
      logic        ev [3] = '{1'b1, 1'b0, 1'b1};
      logic        seen;
      wr(1'b1, 3'h0, 16'h0C00);
      for (k = 0; k < 3; k++) begin
         @(posedge clk);
         {valSign, valMag} <= vin[k];
         wr(1'b0, 3'h0, 16'h0100);
         wr(1'b1, 3'h0, l1[k]);
         wr(1'b0, 3'h0, 16'h0200);
         wr(1'b1, 3'h0, 16'h0110);
         wr(1'b0, 3'h0, 16'h0001);
         waitSig(1, 1'b1, t);
         check(16'(engineOp), 16'(dsc_pkg::OP_COMPARE));
         seen = 1'b0;
         repeat (12) begin
            @(posedge clk);
            #1;
            seen = seen | limitEvent;
            check(16'(result.valid), 16'h0000);
         end
         check(16'(seen), 16'(ev[k]));
         softRst();
      end
   endtask : sWatch

   task automatic sCal();
      @(posedge clk);
      lag <= 4'h9;
      ops.delete();
      wr(1'b0, 3'h0, 16'h000C);
      for (k = 0; k < 2; k++) begin
         waitSig(1, 1'b1, t);
         waitSig(1, 1'b0, t);
      end
      check(16'(ops.size()), 16'h0002);
      check(16'(ops[0]), 16'(dsc_pkg::OP_FULL_CAL));
      check(16'(ops[1]), 16'(dsc_pkg::OP_LONG_AZ));
      rc(1'b0, 3'h0, 16'h0000);
      wr(1'b1, 3'h0, 16'h2074);
      ops.delete();
      conv(16'h0041, t, w);
      waitSig(0, 1'b1, t);
      check(16'(ops.size()), 16'h0002);
      check(16'(ops[0]), 16'(dsc_pkg::OP_SHORT_AZ));
      softRst();
   endtask : sCal

   task automatic sSync();
      wr(1'b0, 3'h0, 16'h0080);
      rc(1'b0, 3'h0, 16'h0080);
      check(16'(syncOe), 16'h0001);
      wr(1'b1, 3'h0, 16'h0100);
      wr(1'b0, 3'h0, 16'h0001);
      waitSig(2, 1'b1, t);
      repeat (30) @(posedge clk);
      #1;
      check(16'({syncOe, engineReq, sampleHold}), 16'h0001);
      @(posedge clk);
      syncIn <= 1'b1;
      waitSig(1, 1'b1, t);
      check(16'(t < 8), 16'h0001);
      waitSig(0, 1'b1, t);
      softRst();
      // With the pin as an output the device paces itself and pulses it.
      wr(1'b0, 3'h0, 16'h0081);
      waitSig(4, 1'b1, t);
      check(16'({syncOe, engineReq}), 16'h0003);
   endtask : sSync

   initial begin
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      sReset();
      sMem();
      sConv();
      sResume();
      sTimer();
      sWatch();
      sCal();
      sSync();
      completeRun();
   end
endmodule : dsc_sequencer_tb_top
